// ---- include/dcw_pkg.sv ----
// dual core wakeup / power handshake: shared constants and carriers
// assumes a 10 MHz always-on clock and an apb slave with 8-bit address
package dcw_pkg;

  // =========================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_MCU_CTRL = 8'h00;
  localparam logic [7:0] REG_WAKE_EN = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_WL_CTRL = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // =========================================================
  // field positions
  localparam int CTRL_LVL_LSB = 0;
  localparam int CTRL_TGT_LSB = 2;
  localparam int CTRL_GO_BIT = 8;
  localparam int FLG_M2W_BIT = 0;
  localparam int FLG_MACT_BIT = 1;
  localparam int FLG_W2M_BIT = 2;
  localparam int FLG_WACT_BIT = 3;
  localparam int WLC_MODE_LSB = 0;
  localparam int WLC_RETAIN_BIT = 2;
  localparam int WLC_CONN_BIT = 3;
  localparam int STS_WL_SLEEP_BIT = 3;
  localparam int STS_REINIT_BIT = 4;
  localparam int STS_PEND_BIT = 5;
  localparam int STS_HITS_LSB = 16;

  // =========================================================
  // reset values
  localparam logic [10:0] WAKE_EN_RST = 11'h000;
  localparam logic [3:0] WL_CTRL_RST = 4'h0;
  localparam logic FLAG_M2W_RST = 1'b0;
  localparam logic FLAG_MACT_RST = 1'b1;

  // =========================================================
  // encodings
  localparam logic [1:0] LVL_TOP = 2'h0;
  localparam logic [1:0] LVL_REDUCED = 2'h1;
  localparam logic [1:0] LVL_LOWEST = 2'h2;
  localparam logic [2:0] TGT_ACTIVE = 3'h0;
  localparam logic [2:0] TGT_STANDBY = 3'h1;
  localparam logic [2:0] TGT_CPU_OFF = 3'h2;
  localparam logic [2:0] TGT_SLEEP = 3'h3;
  localparam logic [2:0] TGT_DEEP = 3'h4;
  localparam logic [1:0] WM_TX = 2'h0;
  localparam logic [1:0] WM_RX = 2'h1;
  localparam logic [1:0] WM_LISTEN = 2'h2;

  // wake source classes, bit 0 is the deep sleep timer
  localparam int WAKE_W = 11;
  localparam logic [10:0] WAKE_ALWAYS = 11'h07f;
  localparam logic [10:0] WAKE_WIRELESS = 11'h080;
  localparam logic [10:0] WAKE_LOW_PWR = 11'h700;

  typedef enum logic [2:0] {
    MCU_ACTIVE, MCU_STANDBY, MCU_CPU_OFF, MCU_SLEEP, MCU_DEEP
  } dcw_mcu_state_t;

  typedef struct packed {
    logic ulp_timer;
    logic converter;
    logic sensor_sampler;
    logic wireless;
    logic watchdog;
    logic msec;
    logic sec;
    logic alarm;
    logic system_rtc;
    logic battery_gpio;
    logic deep_sleep_timer;
  } dcw_wake_src_t;

  typedef struct packed {
    logic core;
    logic modem;
    logic security;
    logic bb_tx;
    logic bb_rx;
    logic bb_rx_full;
    logic afe_tx;
    logic afe_rx;
    logic afe_rx_full;
    logic rfe_tx;
    logic rfe_rx;
    logic sram_on;
    logic pmu_owns;
  } dcw_wl_dom_t;

endpackage

// ---- verilog/dcw_wake_gate.sv ----
// wake permission gate: masks sources by the mcu low-power state
// assumes sources are level interrupts synchronous to pclk
`timescale 1ns/1ns
module dcw_wake_gate (
  input wire logic pclk,
  input wire logic presetn,
  input wire dcw_pkg::dcw_mcu_state_t st,
  input wire logic [1:0] level,
  input wire logic [10:0] src,
  input wire logic [10:0] en,
  output logic wake,
  output logic [10:0] hits
);
  import dcw_pkg::*;

  logic [10:0] allow;
  logic wl_ok;
  logic [10:0] hit_now;

  // =========================================================
  // permission per state
  assign wl_ok = (level == LVL_TOP) || (level == LVL_REDUCED);

  always_comb
  begin
    case (st)
      MCU_STANDBY: allow = WAKE_ALWAYS | WAKE_LOW_PWR |
                           (wl_ok ? WAKE_WIRELESS : 11'h000);
      MCU_CPU_OFF: allow = WAKE_ALWAYS | WAKE_LOW_PWR;
      MCU_SLEEP: allow = WAKE_ALWAYS |
                         (wl_ok ? WAKE_WIRELESS : 11'h000);
      MCU_DEEP: allow = WAKE_ALWAYS;
      default: allow = 11'h000;
    endcase
  end

  // only sources enabled in en at that moment and allowed here count
  genvar i;
  generate
    for (i = 0; i < WAKE_W; i++)
    begin : g_hit
      assign hit_now[i] = src[i] & en[i] & allow[i];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake <= 1'b0;
      hits <= 11'h000;
    end
    else
    begin
      wake <= |hit_now;
      hits <= hit_now;
    end
  end

  chk_always_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (st != MCU_ACTIVE && (src & en & WAKE_ALWAYS) != 11'h000) |=> wake)
    else $error("enabled always-on source did not wake");
  chk_lowest_wl_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (level == LVL_LOWEST && (src & en & ~WAKE_WIRELESS) == 11'h000)
    |=> !wake)
    else $error("wireless source woke from lowest level");
  chk_deep_ulp_mask: assert property (@(posedge pclk) disable iff (!presetn)
    ((st == MCU_SLEEP || st == MCU_DEEP) && (src & en & WAKE_ALWAYS) == 11'h000
     && (src & en & WAKE_WIRELESS) == 11'h000) |=> !wake)
    else $error("low power domain source woke from sleep");
endmodule

// ---- verilog/dcw_wl_power.sv ----
// wireless processor power state and domain controls
// assumes the wireless core drives its sleep request and init done
`timescale 1ns/1ns
module dcw_wl_power (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic retain,
  input wire logic connected,
  input wire logic sleep_req,
  input wire logic rx_busy,
  input wire logic mcu_wake_req,
  input wire logic wake_evt,
  input wire logic init_done,
  output dcw_pkg::dcw_wl_dom_t dom,
  output logic asleep,
  output logic reinit
);
  import dcw_pkg::*;

  typedef enum logic [1:0] {WL_ACT, WL_SLEEP, WL_REINIT} dcw_wl_state_t;
  dcw_wl_state_t st_reg, st_next;
  logic keep_reg;
  dcw_wl_dom_t dom_next;

  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      // sleep is held off while the mcu still wants us awake
      WL_ACT: if (sleep_req && !mcu_wake_req) st_next = WL_SLEEP;
      WL_SLEEP: if (mcu_wake_req || wake_evt)
        st_next = keep_reg ? WL_ACT : WL_REINIT;
      WL_REINIT: if (init_done) st_next = WL_ACT;
      default: st_next = WL_ACT;
    endcase
  end

  always_comb
  begin
    dom_next = '0;
    case (st_next)
      WL_ACT:
      begin
        dom_next = '1;
        dom_next.pmu_owns = 1'b0;
        if (mode == WM_TX)
        begin
          dom_next.bb_rx = 1'b0;
          dom_next.bb_rx_full = 1'b0;
          dom_next.afe_rx = 1'b0;
          dom_next.afe_rx_full = 1'b0;
          dom_next.rfe_rx = 1'b0;
        end
        else
        begin
          dom_next.bb_tx = 1'b0;
          dom_next.afe_tx = 1'b0;
          dom_next.rfe_tx = 1'b0;
          if (mode == WM_LISTEN && !rx_busy)
          begin
            dom_next.bb_rx_full = 1'b0;
            dom_next.afe_rx_full = 1'b0;
          end
        end
      end
      WL_REINIT:
      begin
        dom_next.core = 1'b1;
        dom_next.sram_on = 1'b1;
      end
      default:
      begin
        dom_next.pmu_owns = 1'b1;
        dom_next.sram_on = (st_reg == WL_SLEEP) ? keep_reg :
                           (retain | connected);
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= WL_ACT;
      keep_reg <= 1'b1;
      dom <= '1;
      asleep <= 1'b0;
      reinit <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      dom <= dom_next;
      asleep <= (st_next == WL_SLEEP);
      reinit <= (st_next == WL_REINIT);
      // connected save only offers the retaining variant
      if (st_reg == WL_ACT && st_next == WL_SLEEP)
        keep_reg <= retain | connected;
    end
  end

  chk_connected_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == WL_ACT && sleep_req && !mcu_wake_req && connected)
    |=> dom.sram_on && asleep)
    else $error("connected sleep lost sram");
  chk_reinit_lost: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == WL_SLEEP && !keep_reg && wake_evt) |=> reinit ##0 !dom.modem)
    else $error("no reinit after lost state");
  chk_tx_rx_off: assert property (@(posedge pclk) disable iff (!presetn)
    (st_next == WL_ACT && mode == WM_TX) |=> !dom.bb_rx && dom.bb_tx)
    else $error("rx path on during transmit");
  chk_wl_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == WL_ACT && mcu_wake_req) |=> !asleep)
    else $error("wireless slept against wake request");
endmodule

// ---- verilog/dcw_sequencer.sv ----
// dual core wakeup sequencer: apb registers, mcu power state machine,
// handshake flags and the wireless domain controller
// assumes apb master on pclk, all other inputs synchronous to pclk
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ns
module dcw_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mcu_wfi,
  input wire dcw_pkg::dcw_wake_src_t wake_src,
  input wire logic wireless_to_mcu_wake_request,
  input wire logic wireless_active_flag,
  input wire logic wl_sleep_req,
  input wire logic wl_rx_busy,
  input wire logic wl_wake_evt,
  input wire logic wl_init_done,
  output logic mcu_to_wireless_wake_request,
  output logic mcu_active_flag,
  output logic mcu_clk_gated,
  output logic mcu_pwr_gated,
  output logic mcu_sram_retain,
  output logic mcu_wake,
  output dcw_pkg::dcw_wl_dom_t wl_dom,
  output logic wl_asleep,
  output logic wl_reinit_req
);
  import dcw_pkg::*;

  // =========================================================
  // bus decode
  logic setup;
  logic wr_acc;
  logic mapped;
  logic [31:0] rdata;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & pready & mapped;

  always_comb
  begin
    case (paddr)
      REG_MCU_CTRL, REG_WAKE_EN, REG_FLAGS, REG_WL_CTRL, REG_STATUS:
        mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // =========================================================
  // software registers
  logic [1:0] level_reg;
  logic [2:0] target_reg;
  logic pend_reg;
  logic [10:0] wake_en_reg;
  logic [3:0] wl_ctrl_reg;
  logic [10:0] last_hits_reg;
  logic go;
  logic [2:0] go_tgt;

  assign go = wr_acc && paddr == REG_MCU_CTRL && pwdata[CTRL_GO_BIT];
  assign go_tgt = pwdata[CTRL_TGT_LSB +: 3];

  dcw_mcu_state_t st_reg, st_next;
  logic gate_wake;
  logic [10:0] gate_hits;
  logic entering;
  logic leaving;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_en_reg <= WAKE_EN_RST;
    else if (wr_acc && paddr == REG_WAKE_EN)
      wake_en_reg <= pwdata[10:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wl_ctrl_reg <= WL_CTRL_RST;
    else if (wr_acc && paddr == REG_WL_CTRL)
      wl_ctrl_reg <= pwdata[3:0];
  end

  // level only changes while active; it sets the wireless wake permission
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_reg <= LVL_TOP;
      target_reg <= TGT_ACTIVE;
    end
    else if (wr_acc && paddr == REG_MCU_CTRL && st_reg == MCU_ACTIVE)
    begin
      level_reg <= pwdata[CTRL_LVL_LSB +: 2];
      if (pwdata[CTRL_GO_BIT])
        target_reg <= go_tgt;
    end
  end

  // a go with target active cancels a pending entry
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_reg <= 1'b0;
    else if (entering)
      pend_reg <= 1'b0;
    else if (go && st_reg == MCU_ACTIVE)
      pend_reg <= (go_tgt != TGT_ACTIVE) && (go_tgt <= TGT_DEEP);
  end

  // =========================================================
  // mcu power state machine
  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      MCU_ACTIVE:
        if (pend_reg)
        begin
          case (target_reg)
            TGT_STANDBY: if (mcu_wfi) st_next = MCU_STANDBY;
            TGT_CPU_OFF: st_next = MCU_CPU_OFF;
            TGT_SLEEP:
              if (!wireless_to_mcu_wake_request)
                st_next = MCU_SLEEP;
            TGT_DEEP:
              if (!wireless_to_mcu_wake_request)
                st_next = MCU_DEEP;
            default: st_next = MCU_ACTIVE;
          endcase
        end
      MCU_STANDBY, MCU_CPU_OFF, MCU_SLEEP, MCU_DEEP:
        if (gate_wake) st_next = MCU_ACTIVE;
      default: st_next = MCU_ACTIVE;
    endcase
  end

  assign entering = (st_reg == MCU_ACTIVE) && (st_next != MCU_ACTIVE);
  assign leaving = (st_reg != MCU_ACTIVE) && (st_next == MCU_ACTIVE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= MCU_ACTIVE;
    else
      st_reg <= st_next;
  end

  // standby only gates the clock; everything else keeps running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mcu_clk_gated <= 1'b0;
      mcu_pwr_gated <= 1'b0;
      mcu_sram_retain <= 1'b1;
      mcu_wake <= 1'b0;
    end
    else
    begin
      mcu_clk_gated <= (st_next == MCU_STANDBY);
      mcu_pwr_gated <= (st_next == MCU_CPU_OFF) || (st_next == MCU_SLEEP) ||
                       (st_next == MCU_DEEP);
      mcu_sram_retain <= (st_next != MCU_DEEP);
      mcu_wake <= leaving;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_hits_reg <= 11'h000;
    else if (leaving)
      last_hits_reg <= gate_hits;
  end

  // =========================================================
  // handshake flags; hardware updates override a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mcu_to_wireless_wake_request <= FLAG_M2W_RST;
      mcu_active_flag <= FLAG_MACT_RST;
    end
    else
    begin
      if (wr_acc && paddr == REG_FLAGS)
      begin
        mcu_to_wireless_wake_request <= pwdata[FLG_M2W_BIT];
        mcu_active_flag <= pwdata[FLG_MACT_BIT];
      end
      if (entering)
        mcu_active_flag <= 1'b0;
      else if (leaving)
        mcu_active_flag <= 1'b1;
    end
  end

  // =========================================================
  // read mux
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (paddr)
      REG_MCU_CTRL:
      begin
        rdata[CTRL_LVL_LSB +: 2] = level_reg;
        rdata[CTRL_TGT_LSB +: 3] = target_reg;
      end
      REG_WAKE_EN: rdata[10:0] = wake_en_reg;
      REG_FLAGS:
      begin
        rdata[FLG_M2W_BIT] = mcu_to_wireless_wake_request;
        rdata[FLG_MACT_BIT] = mcu_active_flag;
        rdata[FLG_W2M_BIT] = wireless_to_mcu_wake_request;
        rdata[FLG_WACT_BIT] = wireless_active_flag;
      end
      REG_WL_CTRL: rdata[3:0] = wl_ctrl_reg;
      REG_STATUS:
      begin
        rdata[2:0] = st_reg;
        rdata[STS_WL_SLEEP_BIT] = wl_asleep;
        rdata[STS_REINIT_BIT] = wl_reinit_req;
        rdata[STS_PEND_BIT] = pend_reg;
        rdata[STS_HITS_LSB +: 11] = last_hits_reg;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  // one wait-free access: ready is raised in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (setup)
    begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= rdata;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // =========================================================
  // submodules
  dcw_wake_gate u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .st(st_reg),
    .level(level_reg),
    .src(wake_src),
    .en(wake_en_reg),
    .wake(gate_wake),
    .hits(gate_hits)
  );

  dcw_wl_power u_wl (
    .pclk(pclk),
    .presetn(presetn),
    .mode(wl_ctrl_reg[WLC_MODE_LSB +: 2]),
    .retain(wl_ctrl_reg[WLC_RETAIN_BIT]),
    .connected(wl_ctrl_reg[WLC_CONN_BIT]),
    .sleep_req(wl_sleep_req),
    .rx_busy(wl_rx_busy),
    .mcu_wake_req(mcu_to_wireless_wake_request),
    .wake_evt(wl_wake_evt),
    .init_done(wl_init_done),
    .dom(wl_dom),
    .asleep(wl_asleep),
    .reinit(wl_reinit_req)
  );

  // =========================================================
  // checks
  chk_standby_wfi: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == MCU_ACTIVE ##1 st_reg == MCU_STANDBY) |-> $past(mcu_wfi))
    else $error("standby entered without wfi");
  chk_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == MCU_ACTIVE && wireless_to_mcu_wake_request)
    |=> st_reg != MCU_SLEEP && st_reg != MCU_DEEP)
    else $error("mcu slept against wake request");
  chk_active_clear: assert property (@(posedge pclk) disable iff (!presetn)
    entering |=> !mcu_active_flag && mcu_pwr_gated == (st_reg != MCU_STANDBY))
    else $error("active flag or gating wrong at entry");
  chk_wake_source: assert property (@(posedge pclk) disable iff (!presetn)
    leaving |-> $past(gate_hits & ~wake_en_reg) == 11'h000
    ##1 mcu_wake && !mcu_clk_gated)
    else $error("wake without enabled source");
  chk_disallowed_mask: assert property (@(posedge pclk)
    disable iff (!presetn)
    (st_reg == MCU_CPU_OFF && (wake_src & wake_en_reg) == WAKE_WIRELESS)
    [*2] |=> st_reg == MCU_CPU_OFF)
    else $error("masked source woke cpu-off state");
endmodule

// ---- testbench/dcw_wl_model.sv ----
// wireless processor side model: drives the handshake flags
// assumes testbench commands change just after pclk rising edges
`timescale 1ns/1ns
module dcw_wl_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go_sleep,
  input wire logic need_mcu,
  input wire logic busy_rx,
  input wire logic m2w,
  input wire logic asleep,
  input wire logic reinit,
  output logic w2m,
  output logic wact,
  output logic sreq,
  output logic rx_busy,
  output logic init_done
);
  logic [1:0] init_cnt;
  // ==========
  // driver layer: the only place the wireless flags change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      w2m <= 1'b0;
      wact <= 1'b1;
      sreq <= 1'b0;
      rx_busy <= 1'b0;
      init_done <= 1'b0;
      init_cnt <= 2'h0;
    end
    else
    begin
      w2m <= need_mcu;
      wact <= !go_sleep && !asleep && !reinit;
      // never asks to sleep while the mcu still wants it awake
      sreq <= go_sleep && !m2w;
      rx_busy <= busy_rx;
      // a fresh start takes a few cycles before it reports done
      init_done <= reinit && init_cnt == 2'h3;
      init_cnt <= reinit ? init_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
// testbench: sequencer with the wireless model and apb traffic
// assumes the design package is compiled first
`timescale 1ns/1ns
module tb_top;
  import dcw_pkg::*;
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic mcu_wfi = 1'b0;
  logic wl_wake_evt = 1'b0;
  logic go_sleep = 1'b0;
  logic need_mcu = 1'b0;
  logic busy_rx = 1'b0;
  dcw_wake_src_t wake_src = '0;
  logic [31:0] prdata;
  logic pready, pslverr, w2m, wact, sreq, rxb, idone;
  logic m2w, mact, clk_g, pwr_g, sram_r, mwake, asleep, reinit;
  dcw_wl_dom_t dom;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  dcw_sequencer u_dcw_sequencer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mcu_wfi(mcu_wfi), .wake_src(wake_src),
    .wireless_to_mcu_wake_request(w2m), .wireless_active_flag(wact),
    .wl_sleep_req(sreq), .wl_rx_busy(rxb), .wl_wake_evt(wl_wake_evt),
    .wl_init_done(idone), .mcu_to_wireless_wake_request(m2w),
    .mcu_active_flag(mact), .mcu_clk_gated(clk_g),
    .mcu_pwr_gated(pwr_g), .mcu_sram_retain(sram_r), .mcu_wake(mwake),
    .wl_dom(dom), .wl_asleep(asleep), .wl_reinit_req(reinit));
  dcw_wl_model u_dcw_wl_model (.pclk(pclk), .presetn(presetn),
    .go_sleep(go_sleep), .need_mcu(need_mcu), .busy_rx(busy_rx),
    .m2w(m2w), .asleep(asleep), .reinit(reinit), .w2m(w2m),
    .wact(wact), .sreq(sreq), .rx_busy(rxb), .init_done(idone));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ==========
  // shared tasks
  task automatic complete_run;
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // idle edge at the end keeps back to back calls from double driving
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
  endtask

  task automatic poke(input logic [10:0] bits, output logic w);
    w = 1'b0;
    wake_src <= dcw_wake_src_t'(bits);
    repeat (5)
    begin
      @(posedge pclk);
      if (mwake === 1'b1)
        w = 1'b1;
    end
    wake_src <= '0;
    @(posedge pclk);
  endtask

  task automatic enter(input logic [2:0] t, input logic [1:0] lvl);
    logic [3:0] e;
    wr(REG_MCU_CTRL, {23'h0, 1'b1, 3'h0, t, lvl});
    cyc(4);
    chk(32'(mact), 32'(t == TGT_STANDBY));
    mcu_wfi <= 1'b1;
    cyc(3);
    mcu_wfi <= 1'b0;
    e = {t == TGT_STANDBY, t != TGT_STANDBY, t != TGT_DEEP, 1'b0};
    chk(32'({clk_g, pwr_g, sram_r, mact}), 32'(e));
  endtask

  // ==========
  // scenarios
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    chk(32'({clk_g, pwr_g, sram_r, mwake, m2w, mact}), 32'h9);
    rdc(REG_FLAGS, 32'h0000_000a);
    apb(1'b1, 8'h14, 32'h0000_ffff, r, e);
    chk(32'(e), 32'h1);
    apb(1'b0, 8'h14, 32'h0000_0000, r, e);
    chk({r[30:0], e}, 32'h1);
    rdc(REG_WAKE_EN, 32'(WAKE_EN_RST));
    wr(REG_WAKE_EN, 32'h0000_07ff);
    rdc(REG_WAKE_EN, 32'h0000_07ff);
  endtask

  task automatic sweep(input logic [1:0] lvl);
    logic [10:0] ok;
    logic w;
    for (int t = 1; t <= 4; t++)
    begin
      ok = WAKE_ALWAYS;
      if ((t == 1 || t == 3) && lvl != LVL_LOWEST)
        ok = ok | WAKE_WIRELESS;
      if (t <= 2)
        ok = ok | WAKE_LOW_PWR;
      for (int s = 0; s < WAKE_W; s++)
      begin
        enter(3'(t), lvl);
        poke(11'(1 << s), w);
        chk(32'(w), 32'(ok[s]));
        if (w !== 1'b1)
          poke(11'h001, w);
      end
    end
  endtask

  task automatic t_enable;
    logic w;
    wr(REG_WAKE_EN, 32'h0000_07fe);
    enter(TGT_STANDBY, LVL_TOP);
    poke(11'h001, w);
    chk(32'(w), 32'h0);
    poke(11'h002, w);
    chk(32'(w), 32'h1);
    wr(REG_WAKE_EN, 32'h0000_07ff);
  endtask

  task automatic t_hold;
    logic w;
    need_mcu <= 1'b1;
    cyc(2);
    rdc(REG_FLAGS, 32'h0000_000e);
    wr(REG_MCU_CTRL, {23'h0, 1'b1, 3'h0, TGT_SLEEP, LVL_TOP});
    cyc(4);
    chk(32'(mact), 32'h1);
    need_mcu <= 1'b0;
    cyc(4);
    chk(32'(mact), 32'h0);
    poke(11'h001, w);
    chk(32'(w), 32'h1);
  endtask

  task automatic t_modes;
    logic tx, f;
    logic [12:0] e;
    for (int m = 0; m < 3; m++)
    for (int b = 0; b < 2; b++)
    begin
      wr(REG_WL_CTRL, 32'(m));
      busy_rx <= (b == 1);
      cyc(3);
      tx = (m == 0);
      f = (m == 1) || (m == 2 && b == 1);
      e = {3'h7, tx, !tx, f, tx, !tx, f, tx, !tx, 2'h2};
      chk(32'(dom), 32'(e));
    end
    busy_rx <= 1'b0;
  endtask

  task automatic wl_sleep(input logic ret, input logic con, input logic fl);
    logic [4:0] x;
    wr(REG_WL_CTRL, {28'h0, con, ret, 2'h0});
    go_sleep <= 1'b1;
    cyc(4);
    x = {dom.core, dom.modem, dom.security, dom.sram_on, dom.pmu_owns};
    chk(32'({asleep, x}), 32'({4'h8, ret | con, 1'b1}));
    go_sleep <= 1'b0;
    @(posedge pclk);
    if (fl)
      wr(REG_FLAGS, 32'h0000_0003);
    else
    begin
      wl_wake_evt <= 1'b1;
      @(posedge pclk);
      wl_wake_evt <= 1'b0;
    end
    cyc(2);
    chk(32'(reinit), 32'(!(ret | con)));
    cyc(8);
    chk(32'({asleep, reinit, dom.core}), 32'h1);
    wr(REG_FLAGS, 32'h0000_0002);
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    sweep(LVL_REDUCED);
    sweep(LVL_LOWEST);
    t_enable();
    t_hold();
    t_modes();
    wl_sleep(1'b1, 1'b0, 1'b0);
    wl_sleep(1'b0, 1'b0, 1'b1);
    wl_sleep(1'b0, 1'b1, 1'b0);
    complete_run();
  end
endmodule
